// ==== src/osm_defines.vh ====
`ifndef OSM_DEFINES_VH
`define OSM_DEFINES_VH
// Register subaddress and reset value
`define OSM_ADDR_OUTSEL   8'h16
`define OSM_OUTSEL_RESET  8'h00
`define OSM_RDATA_NONE    8'h00
// Field positions
`define OSM_AUTO_BIT      7
`define OSM_CM_HI         6
`define OSM_CM_LO         4
`define OSM_SRC_HI        1
`define OSM_SRC_LO        0
`define OSM_UNUSED_MASK   8'hf3
// Channel modes
`define OSM_CM_THRU       3'h0
`define OSM_CM_LL         3'h1
`define OSM_CM_RR         3'h2
`define OSM_CM_SWAP       3'h3
`define OSM_CM_AVG        3'h4
// Sources
`define OSM_SRC_FM        2'h0
`define OSM_SRC_NIC       2'h1
`define OSM_SRC_FM_M1     2'h2
`define OSM_SRC_FM_M2     2'h3
// Second channel mode value that forces FM mono under auto-mute
`define OSM_CH2_MUTE      2'h2
`endif

// ==== src/osm_matrix.v ====
`timescale 1ns/10ps
`include "osm_defines.vh"
module osm_matrix #(
    parameter W = 16
) (
    // Clock, reset and enable
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    // Selected pair and mode
    input  wire [2:0]   mode,
    input  wire [W-1:0] in_l,
    input  wire [W-1:0] in_r,
    // Matrixed output
    output reg  [W-1:0] out_l,
    output reg  [W-1:0] out_r
);
    function [W-1:0] avg;
        input [W-1:0] a;
        input [W-1:0] b;
        reg   [W:0]   s;
        begin
            s   = {a[W-1], a} + {b[W-1], b};
            avg = s[W:1];
        end
    endfunction

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            out_l <= {W{1'b0}};
            out_r <= {W{1'b0}};
        end else if (ce) begin
            case (mode)
                `OSM_CM_LL: begin // RQ5
                    out_l <= in_l;
                    out_r <= in_l;
                end
                `OSM_CM_RR: begin // RQ5
                    out_l <= in_r;
                    out_r <= in_r;
                end
                `OSM_CM_SWAP: begin // RQ5
                    out_l <= in_r;
                    out_r <= in_l;
                end
                `OSM_CM_AVG: begin // RQ5
                    out_l <= avg(in_l, in_r);
                    out_r <= avg(in_l, in_r);
                end
                default: begin // RQ15
                    out_l <= in_l;
                    out_r <= in_r;
                end
            endcase
        end
    end
endmodule // osm_matrix

// ==== src/osm_output_select.v ====
`timescale 1ns/10ps
`include "osm_defines.vh"
// Overview of operation
// RQ1: Register resets to all zeros
// RQ2: Eight-bit register at subaddress 22
// RQ3: Auto-select only with FM ident switch high
// RQ4: Auto matrix follows FM/NICAM ident flags
// RQ5: Manual modes: through, LL, RR, swap, average
// RQ6: Controller avoids average in high deviation
// RQ7: Controller writes zero to bits 3, 2
// RQ8: Source field picks output pair
// RQ9: Auto-select only for sources 0 and 1
// RQ10: Auto gives M/M, L/R, A/A or B/B
// RQ11: Auto-mute with mode 10 gives FM mono
// RQ12: FM inputs carry dematrix switching already
// RQ13: Controller sets FM mono before mixed sources
// RQ14: Output disable tri-states data, clock, select
// RQ15: Modes 5 to 7 act as straight through
module osm_output_select #(
    parameter W = 16
) (
    // Clock, reset, enable
    input  wire         clk,
    input  wire         rst,
    input  wire         ce,
    // Subaddressed register port
    input  wire [7:0]   reg_addr,
    input  wire         reg_wr,
    input  wire [7:0]   reg_wdata,
    output reg  [7:0]   reg_rdata,
    // Identification and mode inputs
    input  wire         fm_ident_switch,
    input  wire         fm_stereo_ident_flag,
    input  wire         fm_dual_ident_flag,
    input  wire         nicam_stereo_flag,
    input  wire         nicam_dual_flag,
    input  wire         auto_mute,
    input  wire [1:0]   second_channel_mode,
    input  wire         serial_out_enable,
    // Audio sources
    input  wire [W-1:0] fm_left,
    input  wire [W-1:0] fm_right,
    input  wire [W-1:0] fm_mono,
    input  wire [W-1:0] nicam_left,
    input  wire [W-1:0] nicam_right,
    input  wire [W-1:0] nicam_m1,
    input  wire [W-1:0] nicam_m2,
    // Serial port drivers from the formatter
    input  wire         sd_in,
    input  wire         sck_in,
    input  wire         ws_in,
    // Serial port pins
    output wire         sd_out,
    output wire         sd_oe,
    output wire         sck_out,
    output wire         sck_oe,
    output wire         ws_out,
    output wire         ws_oe,
    // Matrixed audio
    output wire [W-1:0] out_left,
    output wire [W-1:0] out_right,
    output wire [2:0]   eff_mode
);
    reg  [7:0]   sel_r;
    reg  [2:0]   mode_nxt;
    reg  [W-1:0] src_l;
    reg  [W-1:0] src_r;
    wire         auto_matrix_enable;
    wire [2:0]   chan_mode;
    wire [1:0]   src_sel;
    wire         auto_on;
    wire         is_nic;
    reg          st_flag;
    reg          du_flag;
    wire         mute_fm;
    wire         wr_hit;

    // Matrix mode under auto-select once the mute case is ruled out
    function [2:0] auto_mode;
        input       dual;
        input       stereo;
        input [2:0] mode;
        begin
            if (dual) begin
                if (mode == `OSM_CM_RR) begin
                    auto_mode = `OSM_CM_RR;
                end else begin
                    auto_mode = `OSM_CM_LL;
                end
            end else if (stereo) begin
                auto_mode = `OSM_CM_THRU;
            end else begin
                // Mono arrives on both inputs, so it passes straight through
                auto_mode = `OSM_CM_THRU;
            end
        end
    endfunction

    // Mixed FM plus NICAM pairs never take the automatic matrix
    function auto_source;
        input [1:0] src;
        begin
            auto_source = (src == `OSM_SRC_FM) || (src == `OSM_SRC_NIC);
        end
    endfunction

    // Undefined modes above the average act as straight through
    function [2:0] manual_mode;
        input [2:0] mode;
        begin
            if (mode > `OSM_CM_AVG) begin
                manual_mode = `OSM_CM_THRU;
            end else begin
                manual_mode = mode;
            end
        end
    endfunction

    // Only the select register answers; other subaddresses read as zero
    function [7:0] read_byte;
        input [7:0] addr;
        input [7:0] value;
        begin
            if (addr == `OSM_ADDR_OUTSEL) begin
                read_byte = value;
            end else begin
                read_byte = `OSM_RDATA_NONE;
            end
        end
    endfunction

    assign auto_matrix_enable = sel_r[`OSM_AUTO_BIT];
    assign chan_mode = sel_r[`OSM_CM_HI:`OSM_CM_LO];
    assign src_sel   = sel_r[`OSM_SRC_HI:`OSM_SRC_LO];
    assign wr_hit    = ce && reg_wr && reg_addr == `OSM_ADDR_OUTSEL; // RQ2

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            sel_r <= `OSM_OUTSEL_RESET; // RQ1
        end else if (wr_hit) begin
            sel_r <= reg_wdata & `OSM_UNUSED_MASK; // RQ2
        end
    end

    always @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= `OSM_RDATA_NONE;
        end else if (ce) begin
            reg_rdata <= read_byte(reg_addr, sel_r); // RQ2
        end
    end

    assign auto_on = auto_matrix_enable && fm_ident_switch // RQ3
        && auto_source(src_sel); // RQ9
    assign is_nic  = (src_sel == `OSM_SRC_NIC);
    assign mute_fm = auto_mute
        && second_channel_mode == `OSM_CH2_MUTE; // RQ11

    // Sound-mode flags come from the decoder that feeds the chosen pair
    always @* begin
        if (is_nic) begin // RQ4
            st_flag = nicam_stereo_flag;
            du_flag = nicam_dual_flag;
        end else begin // RQ4
            st_flag = fm_stereo_ident_flag;
            du_flag = fm_dual_ident_flag;
        end
    end

    // Sources; FM inputs already carry dematrix switching
    always @* begin
        src_l    = fm_left;
        src_r    = fm_right;
        mode_nxt = manual_mode(chan_mode); // RQ15
        case (src_sel)
            `OSM_SRC_NIC: begin // RQ8
                src_l = nicam_left;
                src_r = nicam_right;
            end
            `OSM_SRC_FM_M1: begin // RQ8
                src_l = fm_mono;
                src_r = nicam_m1;
            end
            `OSM_SRC_FM_M2: begin // RQ8
                src_l = fm_mono;
                src_r = nicam_m2;
            end
            default: begin // RQ12
                src_l = fm_left;
                src_r = fm_right;
            end
        endcase
        if (auto_on) begin
            if (mute_fm) begin // RQ11
                src_l    = fm_mono;
                src_r    = fm_mono;
                mode_nxt = `OSM_CM_THRU;
            end else begin // RQ10
                mode_nxt = auto_mode(du_flag, st_flag, chan_mode);
            end
        end
    end

    osm_matrix #(
        .W(W)
    ) u_matrix (
        .clk   (clk),
        .rst   (rst),
        .ce    (ce),
        .mode  (mode_nxt),
        .in_l  (src_l),
        .in_r  (src_r),
        .out_l (out_left),
        .out_r (out_right)
    );

    assign eff_mode = mode_nxt;
    assign sd_out  = sd_in;
    assign sck_out = sck_in;
    assign ws_out  = ws_in;
    assign sd_oe   = serial_out_enable; // RQ14
    assign sck_oe  = serial_out_enable; // RQ14
    assign ws_oe   = serial_out_enable; // RQ14
endmodule // osm_output_select

// ==== bench/osm_select_checker.sv ====
`timescale 1ns/10ps
module osm_select_checker #(parameter W = 16) (
    // Clock, reset and register port
    input wire         clk, rst, ce, reg_wr,
    input wire [7:0]   reg_addr, reg_wdata, reg_rdata,
    // Mode inputs
    input wire         fm_ident_switch, fm_dual_ident_flag, nicam_dual_flag,
    input wire         auto_mute,
    input wire [1:0]   second_channel_mode,
    // Serial pins and audio
    input wire         serial_out_enable, sd_in, sd_out, sd_oe, ws_oe, sck_oe,
    input wire         sck_in, sck_out, ws_in, ws_out,
    input wire [W-1:0] fm_left, fm_right, fm_mono, out_left, out_right,
    input wire [2:0]   eff_mode
);
    reg  [7:0] shadow_r;
    wire [2:0] cm      = shadow_r[6:4] > 3'h4 ? 3'h0 : shadow_r[6:4];
    wire       auto_on = shadow_r[7] & fm_ident_switch & ~shadow_r[1];
    wire       mute    = auto_mute & (second_channel_mode == 2'h2);
    wire       dual    = shadow_r[0] ? nicam_dual_flag : fm_dual_ident_flag;
    // Expected register contents, kept apart from the block's copy
    always @(posedge clk or posedge rst)
        if (rst) shadow_r <= 8'h00;
        else if (ce && reg_wr && reg_addr == 8'h16)
            shadow_r <= reg_wdata & 8'hf3;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    chk_pin_enable: assert property ({sd_oe, ws_oe, sck_oe} ==
        {3{serial_out_enable}} && sd_out == sd_in && sck_out == sck_in
        && ws_out == ws_in) else $error("pin enable");
    chk_read_other: assert property (ce && reg_addr != 8'h16
        |=> reg_rdata == 8'h00) else $error("foreign read not zero");
    chk_write_read: assert property (ce && reg_wr && reg_addr == 8'h16
        ##1 ce && reg_addr == 8'h16 |=> reg_rdata == ($past(reg_wdata, 2)
        & 8'hf3)) else $error("readback mismatch");
    chk_manual_mode: assert property (!shadow_r[7] || !fm_ident_switch
        |-> eff_mode == cm) else $error("manual mode");
    chk_mixed_manual: assert property (shadow_r[1] |-> eff_mode == cm)
        else $error("auto acted on mixed source");
    chk_auto_dual: assert property (auto_on && !mute && dual
        |-> eff_mode == (shadow_r[6:4] == 3'h2 ? 3'h2 : 3'h1))
        else $error("dual mode");
    chk_auto_plain: assert property (auto_on && !mute && !dual
        |-> eff_mode == 3'h0) else $error("mono or stereo mode");
    chk_mute_mono: assert property (ce && auto_on && mute
        |=> out_left == $past(fm_mono) && out_right == $past(fm_mono))
        else $error("mute mono");
    chk_fm_through: assert property (ce && shadow_r[1:0] == 2'h0 &&
        eff_mode == 3'h0 && !(auto_on && mute) |=> out_left == $past(fm_left)
        && out_right == $past(fm_right)) else $error("fm through");
    cover property (auto_on && dual && !mute);
    cover property (auto_on && mute);
    cover property (shadow_r[6:4] == 3'h4);
endmodule // osm_select_checker
bind osm_output_select osm_select_checker #(.W(W)) CHK (.*);

// ==== bench/osm_rx_model.sv ====
`timescale 1ns/10ps
module osm_rx_model (
    // Pins and matrixed words from the block
    input wire        clk, sd_out, sd_oe,
    input wire [15:0] out_left, out_right,
    // What the receiver takes in
    output wire       rx_sd,
    output reg [15:0] rx_l, rx_r
);
    // Released line reads inverted, so a missed release shows up
    assign rx_sd = sd_oe ? sd_out : ~sd_out;
    always @(posedge clk) begin
        rx_l <= out_left;
        rx_r <= out_right;
    end
endmodule // osm_rx_model

// ==== bench/i2s_output_source_matrix_test.sv ====
`timescale 1ns/10ps
module i2s_output_source_matrix_test;
    logic clk = 0, rst = 1, ce = 1, reg_wr = 0, fm_ident_switch = 0;
    logic fm_stereo_ident_flag = 0, fm_dual_ident_flag = 0, nicam_dual_flag = 0;
    logic nicam_stereo_flag = 0, auto_mute = 0, serial_out_enable = 1;
    logic sd_in = 0, sck_in = 0, ws_in = 0;
    logic [1:0] second_channel_mode = 2'h0;
    logic [7:0] reg_addr = 8'h16, reg_wdata = 8'h00;
    logic [15:0] fm_left = 16'h1111, fm_right = 16'h2222, fm_mono = 16'h3333;
    logic [15:0] nicam_left = 16'h4444, nicam_right = 16'h5555;
    logic [15:0] nicam_m1 = 16'h6666, nicam_m2 = 16'h7777;
    wire [7:0]  reg_rdata;
    wire [15:0] out_left, out_right, rx_l, rx_r;
    wire [2:0]  eff_mode;
    wire        sd_out, sd_oe, sck_out, sck_oe, ws_out, ws_oe, rx_sd;
    int err_count = 0, checks_done = 0;
    osm_output_select #(.W(16)) DUT (.*);
    osm_rx_model RX (.*);
    always #20 clk = ~clk;
    task close_out;
        if (err_count == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk) #1;
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(posedge clk) #1;
        {reg_addr, reg_wr} = {8'h16, 1'b0};
    endtask
    task rd(input [7:0] a, input [7:0] e);
        @(posedge clk) #1 reg_addr = a;
        @(posedge clk) #1 chk({8'h00, reg_rdata}, {8'h00, e});
        reg_addr = 8'h16;
    endtask
    // Write the select byte, then judge what the receiver latched
    task run(input [7:0] v, input [15:0] el, input [15:0] er);
        wr(8'h16, v);
        repeat (3) @(posedge clk);
        #1 chk(rx_l, el);
        chk(rx_r, er);
    endtask
    task t_regs;
        rd(8'h16, 8'h00);
        wr(8'h16, 8'hf3);
        rd(8'h16, 8'hf3);
        rd(8'h00, 8'h00);
        wr(8'h15, 8'h11);
        rd(8'h16, 8'hf3);
    endtask
    task t_manual;
        run(8'h00, 16'h1111, 16'h2222);
        run(8'h10, 16'h1111, 16'h1111);
        run(8'h20, 16'h2222, 16'h2222);
        run(8'h30, 16'h2222, 16'h1111);
        run(8'h40, 16'h1999, 16'h1999);
        for (int m = 5; m < 8; m++) run(8'(m << 4), 16'h1111, 16'h2222);
    endtask
    task t_source;
        fm_ident_switch = 1;
        run(8'h01, 16'h4444, 16'h5555);
        run(8'h02, 16'h3333, 16'h6666);
        run(8'h03, 16'h3333, 16'h7777);
        fm_ident_switch = 0;
    endtask
    // Frozen writes are lost; a second reset clears the register
    task t_freeze;
        ce = 0;
        wr(8'h16, 8'h30);
        ce = 1;
        rd(8'h16, 8'hb1);
        rst = 1;
        @(posedge clk) #1 rst = 0;
        rd(8'h16, 8'h00);
    endtask
    task t_auto;
        fm_dual_ident_flag = 1;
        run(8'h80, 16'h1111, 16'h2222);
        fm_ident_switch = 1;
        run(8'h90, 16'h1111, 16'h1111);
        run(8'ha0, 16'h2222, 16'h2222);
        run(8'h82, 16'h3333, 16'h6666);
        {auto_mute, second_channel_mode} = 3'h6;
        run(8'h80, 16'h3333, 16'h3333);
        {auto_mute, fm_dual_ident_flag, nicam_dual_flag} = 3'h1;
        run(8'h81, 16'h4444, 16'h4444);
        {nicam_dual_flag, nicam_stereo_flag} = 2'h1;
        run(8'hb1, 16'h4444, 16'h5555);
    endtask
    task t_pins;
        @(posedge clk) #1 {sd_in, sck_in, ws_in} = 3'h7;
        @(posedge clk) #1 chk({15'h0000, rx_sd}, 16'h0001);
        serial_out_enable = 0;
        @(posedge clk) #1 chk({15'h0000, rx_sd}, 16'h0000);
        serial_out_enable = 1;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        #1 rst = 0;
        t_regs();
        t_manual();
        t_source();
        t_auto();
        t_freeze();
        t_pins();
        close_out();
    end
    initial begin
        #100000;
        err_count++;
        close_out();
    end
endmodule // i2s_output_source_matrix_test
